// ### verilog/flash_command_status_ctrl.sv
// Command launch and status logic of the on-chip flash, reached over APB.
// Assumes a single 25 MHz clock, a stop request pin from another domain.
//
// Function
// - Writing one to buffer-empty bit 7 clears it and launches the command.
// - Only burst programs queue; buffer-empty sets on hand-over, clears on launch.
// - Complete bit 6 sets when idle and empty, clears on launch, ignores writes.
// - Program or erase of a protected location is dropped and sets bit 5.
// - Bad sequence, unset divider on program or erase, or stop mid-command sets bit 4, drops command.
// - Writing one clears the access error; writing zero changes nothing.
// - A passing blank check sets bit 2; a new valid launch clears it.
// - Blank means every location reads all ones once complete is set.
// - Codes for blank check, byte program and burst program are recognized.
// - Page erase clears one 512 byte page; mass erase clears everything.
// - Any other code is illegal: access error, no execution.
// - Protected locations are never programmed; a page erase below the boundary can clear the protected part of its page.
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module flash_command_status_ctrl #(
   parameter int unsigned ADDR_W = 12
) (
   // Clock, reset, enable
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic        clk_en,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // System
   input  wire logic        stop_req,
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   logic [7:0]               cmd_reg;
   logic [6:0]               div_reg;
   logic                     div_set_reg;
   logic [7:0]               prot_reg;
   logic [23:0]              target_reg;
   logic [2:0]               irq_stat_reg;
   logic [2:0]               irq_mask_reg;
   flash_cmd_pkg::seq_e      seq_reg;
   flash_cmd_pkg::flash_cmd_s pend_reg;
   logic                     pend_valid_reg;
   flash_cmd_pkg::flash_op_e run_op_reg;
   logic                     cbe_reg;
   logic                     ccf_reg;
   logic                     pviol_reg;
   logic                     accerr_reg;
   logic                     blank_reg;
   logic [6:0]               div_cnt_reg;
   logic                     stop_s1_reg;
   logic                     stop_s2_reg;
   logic                     stop_s3_reg;
   logic                     eng_busy;
   logic                     eng_done;
   logic                     eng_blank_ok;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   wire logic acc       = psel && penable && pready;
   wire logic wr        = acc && pwrite;
   wire logic sel_stat  = (paddr == flash_cmd_pkg::OFF_STATUS);
   wire logic sel_cmd   = (paddr == flash_cmd_pkg::OFF_COMMAND);
   wire logic sel_div   = (paddr == flash_cmd_pkg::OFF_DIVIDER);
   wire logic sel_prot  = (paddr == flash_cmd_pkg::OFF_PROTECT);
   wire logic sel_tgt   = (paddr == flash_cmd_pkg::OFF_TARGET);
   wire logic sel_istat = (paddr == flash_cmd_pkg::OFF_IRQ_STAT);
   wire logic sel_imask = (paddr == flash_cmd_pkg::OFF_IRQ_MASK);
   wire logic mapped    = sel_stat || sel_cmd || sel_div || sel_prot || sel_tgt
                          || sel_istat || sel_imask;
   wire logic wr_stat   = wr && sel_stat;
   wire logic wr_cmd    = wr && sel_cmd;
   wire logic wr_tgt    = wr && sel_tgt;

   wire logic [7:0] status_byte = {cbe_reg, ccf_reg, pviol_reg, accerr_reg,
                                   1'b0, blank_reg, 2'b00};
   wire logic [31:0] rd_word =
      sel_stat  ? {24'h00_0000, status_byte} :
      sel_cmd   ? {24'h00_0000, cmd_reg} :
      sel_div   ? {24'h00_0000, div_set_reg, div_reg} :
      sel_prot  ? {24'h00_0000, prot_reg} :
      sel_tgt   ? {8'h00, target_reg} :
      sel_istat ? {29'h0000_0000, irq_stat_reg} :
      sel_imask ? {29'h0000_0000, irq_mask_reg} : 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // Command decode and checks
   wire flash_cmd_pkg::flash_op_e new_op =
      (cmd_reg == flash_cmd_pkg::CMD_BYTE)  ? flash_cmd_pkg::OP_BYTE :
      (cmd_reg == flash_cmd_pkg::CMD_BURST) ? flash_cmd_pkg::OP_BURST :
      (cmd_reg == flash_cmd_pkg::CMD_PAGE)  ? flash_cmd_pkg::OP_PAGE :
      (cmd_reg == flash_cmd_pkg::CMD_MASS)  ? flash_cmd_pkg::OP_MASS :
      flash_cmd_pkg::OP_BLANK;
   wire logic code_legal = (cmd_reg == flash_cmd_pkg::CMD_BLANK) || (cmd_reg == flash_cmd_pkg::CMD_BYTE)
      || (cmd_reg == flash_cmd_pkg::CMD_BURST) || (cmd_reg == flash_cmd_pkg::CMD_PAGE)
      || (cmd_reg == flash_cmd_pkg::CMD_MASS);
   wire logic new_burst  = (new_op == flash_cmd_pkg::OP_BURST);
   wire logic new_alters = (new_op != flash_cmd_pkg::OP_BLANK);

   // Protected block sits at the top of the array, above the boundary field
   wire logic prot_on  = !prot_reg[flash_cmd_pkg::BIT_PROT_DIS];
   wire logic addr_hit = (target_reg[ADDR_W+7 -: 7] >= prot_reg[6:0]);
   wire logic prot_hit = prot_on && new_alters
                         && ((new_op == flash_cmd_pkg::OP_MASS) || addr_hit);

   // Only a burst may follow a running burst; anything else is refused with an access error
   wire logic run_burst  = eng_busy && (run_op_reg == flash_cmd_pkg::OP_BURST);
   wire logic busy_clash = eng_busy && !(run_burst && new_burst);
   wire logic launch_req = wr_stat && pwdata[flash_cmd_pkg::BIT_CBE];
   wire logic seq_bad    = (seq_reg != flash_cmd_pkg::SEQ_CMD) || !cbe_reg;
   wire logic launch_err = launch_req && (seq_bad || !code_legal
                           || (new_alters && !div_set_reg) || busy_clash);
   wire logic launch_pv  = launch_req && !launch_err && prot_hit;
   wire logic launch_ok  = launch_req && !launch_err && !prot_hit;
   wire logic tgt_err    = wr_tgt && ((seq_reg != flash_cmd_pkg::SEQ_IDLE) || !cbe_reg);
   wire logic cmd_err    = wr_cmd && (seq_reg != flash_cmd_pkg::SEQ_DATA);
   wire logic stop_err   = stop_s2_reg && !stop_s3_reg && (eng_busy || pend_valid_reg);
   wire logic acc_event  = launch_err || tgt_err || cmd_err || stop_err;

   ////////////////////////////////////////////////////////////////////////////
   // Buffer, flags, engine hand-over
   wire logic hand        = pend_valid_reg && !eng_busy && !stop_err;
   wire logic pend_next   = launch_ok || (pend_valid_reg && !hand && !stop_err);
   wire logic cbe_next    = !pend_next;
   wire logic ccf_next    = !pend_next && !hand && !eng_busy;
   wire logic step_en     = (div_cnt_reg == 7'h00);
   wire logic ev_blank    = eng_done && (run_op_reg == flash_cmd_pkg::OP_BLANK) && eng_blank_ok;
   wire logic [2:0] ev_irq = {acc_event, launch_pv, ccf_next && !ccf_reg};
   wire logic [2:0] irq_clr = (wr && sel_istat) ? pwdata[2:0] : 3'h0;

   wire flash_cmd_pkg::flash_cmd_s new_cmd = '{op: new_op, addr: target_reg[23:8],
                                              data: target_reg[7:0]};

   flash_array_engine #(
      .ADDR_W     (ADDR_W),
      .PAGE_BYTES (flash_cmd_pkg::PAGE_BYTES)
   ) u_engine (
      .ref_clk  (ref_clk),
      .rst_b    (rst_b),
      .clk_en   (clk_en),
      .start    (hand),
      .cmd      (pend_reg),
      .step_en  (step_en),
      .abort    (stop_err),
      .busy     (eng_busy),
      .done     (eng_done),
      .blank_ok (eng_blank_ok)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Bus answer: one wait state, then pready for a single cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (clk_en) begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         prdata  <= (psel && penable && !pready && !pwrite) ? rd_word : 32'h0000_0000;
      end
   end

   // Software registers
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         cmd_reg      <= flash_cmd_pkg::COMMAND_RST;
         div_reg      <= flash_cmd_pkg::DIVIDER_RST;
         div_set_reg  <= 1'b0;
         prot_reg     <= flash_cmd_pkg::PROTECT_RST;
         target_reg   <= flash_cmd_pkg::TARGET_RST;
         irq_mask_reg <= flash_cmd_pkg::IRQ_MASK_RST;
      end else if (clk_en) begin
         if (wr_cmd && !cmd_err) cmd_reg <= pwdata[7:0];
         if (wr_tgt && !tgt_err) target_reg <= pwdata[23:0];
         if (wr && sel_prot) prot_reg <= pwdata[7:0];
         if (wr && sel_imask) irq_mask_reg <= pwdata[2:0];
         if (wr && sel_div) begin
            div_reg     <= pwdata[6:0];
            div_set_reg <= 1'b1;
         end
      end
   end

   // Command sequence tracker; any slip returns it to idle
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         seq_reg <= flash_cmd_pkg::SEQ_IDLE;
      end else if (clk_en) begin
         if (acc_event || launch_req) seq_reg <= flash_cmd_pkg::SEQ_IDLE;
         else if (wr_tgt) seq_reg <= flash_cmd_pkg::SEQ_DATA;
         else if (wr_cmd) seq_reg <= flash_cmd_pkg::SEQ_CMD;
      end
   end

   // Command buffer and running command
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         pend_reg       <= '{op: flash_cmd_pkg::OP_BLANK, addr: 16'h0000, data: 8'h00};
         pend_valid_reg <= 1'b0;
         run_op_reg     <= flash_cmd_pkg::OP_BLANK;
         cbe_reg        <= 1'b1;
         ccf_reg        <= 1'b1;
      end else if (clk_en) begin
         pend_valid_reg <= pend_next;
         cbe_reg        <= cbe_next;
         ccf_reg        <= ccf_next;
         if (launch_ok) pend_reg <= new_cmd;
         if (hand) run_op_reg <= pend_reg.op;
      end
   end

   // Error and result flags; a new event wins over a clearing write
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         pviol_reg  <= 1'b0;
         accerr_reg <= 1'b0;
         blank_reg  <= 1'b0;
      end else if (clk_en) begin
         pviol_reg  <= launch_pv
                       || (pviol_reg && !(wr_stat && pwdata[flash_cmd_pkg::BIT_PVIOL]));
         accerr_reg <= acc_event
                       || (accerr_reg && !(wr_stat && pwdata[flash_cmd_pkg::BIT_ACCERR]));
         blank_reg  <= ev_blank || (blank_reg && !launch_ok);
      end
   end

   // Array pacing divider
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         div_cnt_reg <= flash_cmd_pkg::DIVIDER_RST;
      end else if (clk_en) begin
         div_cnt_reg <= step_en ? div_reg : div_cnt_reg - 7'h01;
      end
   end

   // Stop request crosses in from the system controller
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         stop_s1_reg <= 1'b0;
         stop_s2_reg <= 1'b0;
         stop_s3_reg <= 1'b0;
      end else if (clk_en) begin
         stop_s1_reg <= stop_req;
         stop_s2_reg <= stop_s1_reg;
         stop_s3_reg <= stop_s2_reg;
      end
   end

   // Interrupt status, sticky with write-one-to-clear
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         irq_stat_reg <= 3'h0;
         irq          <= 1'b0;
      end else if (clk_en) begin
         irq_stat_reg <= ev_irq | (irq_stat_reg & ~irq_clr);
         irq          <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence s_hand;
      clk_en && hand;
   endsequence
   sequence s_launch;
      clk_en && launch_ok;
   endsequence

   chk_launch_clears_cbe: assert property (s_launch |=> !cbe_reg && !ccf_reg)
      else $error("launch left buffer-empty or complete set");
   chk_handover_frees: assert property (s_hand |=> cbe_reg && eng_busy)
      else $error("hand-over did not free the buffer");
   chk_ccf_when_idle: assert property (
      (clk_en && !pend_valid_reg && !eng_busy)[*2] |-> ccf_reg)
      else $error("complete flag low while idle");
   chk_pviol_sets: assert property (
      clk_en && launch_pv |=> pviol_reg && !pend_valid_reg && cbe_reg)
      else $error("protection violation not flagged");
   chk_illegal_code: assert property (
      clk_en && launch_req && !code_legal |=> accerr_reg && !$rose(pend_valid_reg))
      else $error("illegal code not refused");
   chk_accerr_w0: assert property (
      clk_en && wr_stat && !pwdata[flash_cmd_pkg::BIT_ACCERR] && accerr_reg |=> accerr_reg)
      else $error("writing zero cleared the access error");
   chk_blank_sets: assert property (clk_en && ev_blank |=> blank_reg)
      else $error("passing blank check not reported");
   chk_legal_accept: assert property (s_launch |-> code_legal
      ##1 pend_reg.op == $past(new_op))
      else $error("accepted command lost its code");
   chk_mass_protect: assert property (
      clk_en && launch_req && prot_on && (cmd_reg == flash_cmd_pkg::CMD_MASS) |-> !launch_ok)
      else $error("mass erase accepted with protection on");

endmodule : flash_command_status_ctrl
`default_nettype wire

// ### common/flash_cmd_pkg.sv
// Constants, codes and carrier types of the flash command and status logic.
// Assumes a 32-bit APB register port and a byte-wide on-chip flash array.
package flash_cmd_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFF_STATUS   = 8'h00;
   localparam logic [7:0] OFF_COMMAND  = 8'h04;
   localparam logic [7:0] OFF_DIVIDER  = 8'h08;
   localparam logic [7:0] OFF_PROTECT  = 8'h0C;
   localparam logic [7:0] OFF_TARGET   = 8'h10;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

   ////////////////////////////////////////////////////////////////////////////
   // Status field positions
   localparam int unsigned BIT_CBE    = 7;
   localparam int unsigned BIT_CCF    = 6;
   localparam int unsigned BIT_PVIOL  = 5;
   localparam int unsigned BIT_ACCERR = 4;
   localparam int unsigned BIT_BLANK  = 2;
   // Divider: bit 7 reads back the loaded marker, DIV in 6:0
   localparam int unsigned BIT_DIV_SET = 7;
   // Protection: bit 7 disables, 6:0 boundary of the protected top block
   localparam int unsigned BIT_PROT_DIS = 7;
   // Interrupt status and mask layout
   localparam int unsigned IRQ_DONE   = 0;
   localparam int unsigned IRQ_PVIOL  = 1;
   localparam int unsigned IRQ_ACCERR = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0]  COMMAND_RST  = 8'h00;
   localparam logic [6:0]  DIVIDER_RST  = 7'h00;
   localparam logic [7:0]  PROTECT_RST  = 8'h80;
   localparam logic [23:0] TARGET_RST   = 24'h00_0000;
   localparam logic [2:0]  IRQ_MASK_RST = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Command codes and array facts
   localparam logic [7:0]  CMD_BLANK    = 8'h05;
   localparam logic [7:0]  CMD_BYTE     = 8'h20;
   localparam logic [7:0]  CMD_BURST    = 8'h25;
   localparam logic [7:0]  CMD_PAGE     = 8'h40;
   localparam logic [7:0]  CMD_MASS     = 8'h41;
   localparam int unsigned PAGE_BYTES   = 512;
   localparam logic [7:0]  ERASED_BYTE  = 8'hFF;

   typedef enum logic [4:0] {
      OP_BLANK = 5'h01,
      OP_BYTE  = 5'h02,
      OP_BURST = 5'h04,
      OP_PAGE  = 5'h08,
      OP_MASS  = 5'h10
   } flash_op_e;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'h1,
      SEQ_DATA = 3'h2,
      SEQ_CMD  = 3'h4
   } seq_e;

   typedef enum logic [1:0] {
      ENG_IDLE = 2'h1,
      ENG_RUN  = 2'h2
   } eng_e;

   typedef struct packed {
      flash_op_e   op;
      logic [15:0] addr;
      logic [7:0]  data;
   } flash_cmd_s;

endpackage : flash_cmd_pkg

// ### verilog/flash_array_engine.sv
// Flash array and the engine that walks it for one command at a time.
// Assumes the caller starts it only while idle and paces it with step_en.
`timescale 1ns/1ns
`default_nettype none
module flash_array_engine #(
   parameter int unsigned ADDR_W     = 12,
   parameter int unsigned PAGE_BYTES = flash_cmd_pkg::PAGE_BYTES
) (
   // Clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     rst_b,
   input  wire logic                     clk_en,
   // Command hand-over
   input  wire logic                     start,
   input  wire flash_cmd_pkg::flash_cmd_s cmd,
   input  wire logic                     step_en,
   input  wire logic                     abort,
   // Progress
   output logic                          busy,
   output logic                          done,
   output logic                          blank_ok
);
   localparam int unsigned DEPTH = 2 ** ADDR_W;

   logic [7:0]              mem [DEPTH];
   flash_cmd_pkg::eng_e     state_reg;
   flash_cmd_pkg::flash_op_e op_reg;
   logic [ADDR_W-1:0]       idx_reg;
   logic [ADDR_W-1:0]       cnt_reg;
   logic [7:0]              data_reg;
   logic                    ok_reg;

   wire logic whole  = (cmd.op == flash_cmd_pkg::OP_MASS) || (cmd.op == flash_cmd_pkg::OP_BLANK);
   wire logic page   = (cmd.op == flash_cmd_pkg::OP_PAGE);
   wire logic [ADDR_W-1:0] page_mask = ~ADDR_W'(PAGE_BYTES - 1);
   wire logic [ADDR_W-1:0] base  = whole ? '0 : page ? (cmd.addr[ADDR_W-1:0] & page_mask)
                                  : cmd.addr[ADDR_W-1:0];
   wire logic [ADDR_W-1:0] len_m1 = whole ? ADDR_W'(DEPTH - 1) : page ? ADDR_W'(PAGE_BYTES - 1)
                                   : '0;
   wire logic run    = (state_reg == flash_cmd_pkg::ENG_RUN);
   wire logic step   = run && step_en && !abort;
   wire logic last   = step && (cnt_reg == '0);
   wire logic is_erased = (mem[idx_reg] == flash_cmd_pkg::ERASED_BYTE);
   wire logic is_prog = (op_reg == flash_cmd_pkg::OP_BYTE) || (op_reg == flash_cmd_pkg::OP_BURST);
   wire logic [7:0] wr_byte = is_prog ? (mem[idx_reg] & data_reg) : flash_cmd_pkg::ERASED_BYTE;

   assign busy = run;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencing
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         state_reg <= flash_cmd_pkg::ENG_IDLE;
         op_reg    <= flash_cmd_pkg::OP_BLANK;
         idx_reg   <= '0;
         cnt_reg   <= '0;
         data_reg  <= 8'h00;
         ok_reg    <= 1'b0;
         done      <= 1'b0;
         blank_ok  <= 1'b0;
      end else if (clk_en) begin
         done <= last;
         if (abort) begin
            state_reg <= flash_cmd_pkg::ENG_IDLE;
         end else if (start && !run) begin
            state_reg <= flash_cmd_pkg::ENG_RUN;
            op_reg    <= cmd.op;
            idx_reg   <= base;
            cnt_reg   <= len_m1;
            data_reg  <= cmd.data;
            ok_reg    <= 1'b1;
         end else if (step) begin
            ok_reg  <= ok_reg && is_erased;
            idx_reg <= idx_reg + ADDR_W'(1);
            cnt_reg <= cnt_reg - ADDR_W'(1);
            if (last) begin
               state_reg <= flash_cmd_pkg::ENG_IDLE;
               blank_ok  <= ok_reg && is_erased;
            end
         end
      end
   end

   // Programming only clears bits, as a real cell cannot be raised without erase
   always_ff @(posedge ref_clk) begin
      if (clk_en && step && (op_reg != flash_cmd_pkg::OP_BLANK)) begin
         mem[idx_reg] <= wr_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   chk_blank_all_ones: assert property (
      clk_en && last && (op_reg == flash_cmd_pkg::OP_BLANK) && !is_erased |=> !blank_ok)
      else $error("blank check passed over a programmed byte");
   chk_page_length: assert property (
      clk_en && start && !run && !abort && page |=> cnt_reg == ADDR_W'(PAGE_BYTES - 1))
      else $error("page erase does not span one page");

endmodule : flash_array_engine
`default_nettype wire

// ### verif/stop_source.sv
// Model of the system side that asks the chip to enter stop mode.
// Assumes one clock; the request follows the bench trigger by one edge.
`timescale 1ns/1ns
`default_nettype none
module stop_source (
   // Clock and trigger
   input  wire logic ref_clk,
   input  wire logic trig,
   // Stop request
   output logic      stop_req
);
   always_ff @(posedge ref_clk) begin
      stop_req <= trig;
   end
endmodule : stop_source
`default_nettype wire

// ### verif/flash_command_status_ctrl_tb.sv
// Self-checking bench of the flash command and status logic over APB.
// Assumes ADDR_W of 10 and a divider of 0 until the last test, so counts stay short.
`timescale 1ns/1ns
`default_nettype none
module flash_command_status_ctrl_tb;
   logic        ref_clk = 1'b0;
   logic        rst_b   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic        trig    = 1'b0;
   logic        en      = 1'b1;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [31:0] prdata, r;
   logic        pready, pslverr, irq, stop_req, e;
   int          miscompares = 0;
   int          cmp_count   = 0;
   // Rows: code, target data, status expected once complete
   logic [7:0]  rc [8] = '{8'h41, 8'h05, 8'h20, 8'h05, 8'h40, 8'h05, 8'h25, 8'h33};
   logic [7:0]  rd [8] = '{8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF};
   logic [7:0]  rx [8] = '{8'hC0, 8'hC4, 8'hC0, 8'hC0, 8'hC0, 8'hC4, 8'hC0, 8'hD0};
   flash_command_status_ctrl #(.ADDR_W(10)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
      .clk_en(en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .stop_req(stop_req), .irq(irq));
   stop_source SRC (.ref_clk(ref_clk), .trig(trig), .stop_req(stop_req));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      cmp_count++;
      if (g !== x) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   // Order kept: target, then code, then launch
   task automatic launch(input logic [7:0] c, input logic [7:0] d);
      apb(1'b1, 8'h10, {24'h00_0000, d});
      apb(1'b1, 8'h04, {24'h00_0000, c});
      apb(1'b1, 8'h00, 32'h0000_0080);
   endtask : launch
   // Extra read after complete, though blank sets on the same edge as complete
   task automatic wait_done;
      do begin
         apb(1'b0, 8'h00, 32'h0000_0000);
      end while (r[6] !== 1'b1);
      apb(1'b0, 8'h00, 32'h0000_0000);
   endtask : wait_done
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #2400000;
      miscompares++;
      print_verdict();
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      rst_b <= 1'b1;
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("status reset", 32'h0000_00C0, r);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk("protect reset", 32'h0000_0080, r);
      apb(1'b1, 8'h18, 32'h0000_0004);
      launch(8'h41, 8'hFF);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("no divider", 32'h0000_00D0, r);
      chk("irq raised", 32'h0000_0001, {31'h0, irq});
      apb(1'b1, 8'h18, 32'h0000_0000);
      repeat (2) @(posedge ref_clk);
      chk("irq masked", 32'h0000_0000, {31'h0, irq});
      apb(1'b1, 8'h14, 32'h0000_0007);
      apb(1'b1, 8'h18, 32'h0000_0004);
      repeat (2) @(posedge ref_clk);
      chk("irq cleared", 32'h0000_0000, {31'h0, irq});
      apb(1'b1, 8'h00, 32'h0000_0000);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("zero write", 32'h0000_00D0, r);
      apb(1'b1, 8'h00, 32'h0000_0010);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("one write", 32'h0000_00C0, r);
      apb(1'b1, 8'h08, 32'h0000_0000);
      apb(1'b0, 8'h08, 32'h0000_0000);
      chk("divider loaded", 32'h0000_0080, r);
      $display("test setup done");
      for (int i = 0; i < 8; i++) begin
         launch(rc[i], rd[i]);
         wait_done();
         chk("row status", {24'h00_0000, rx[i]}, r);
         apb(1'b1, 8'h00, 32'h0000_0030);
      end
      $display("test commands done");
      apb(1'b1, 8'h0C, 32'h0000_0000);
      launch(8'h40, 8'hFF);
      wait_done();
      chk("protected erase", 32'h0000_00E0, r);
      apb(1'b1, 8'h00, 32'h0000_0030);
      // Boundary clear of address 0: mass erase must still be refused
      apb(1'b1, 8'h0C, 32'h0000_007F);
      launch(8'h41, 8'hFF);
      wait_done();
      chk("protected mass", 32'h0000_00E0, r);
      apb(1'b1, 8'h00, 32'h0000_0030);
      apb(1'b1, 8'h0C, 32'h0000_0080);
      launch(8'h05, 8'hFF);
      wait_done();
      chk("contents kept", 32'h0000_00C0, r);
      $display("test protection done");
      apb(1'b1, 8'h04, 32'h0000_0020);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("code first", 32'h0000_00D0, r);
      apb(1'b1, 8'h00, 32'h0000_0030);
      apb(1'b1, 8'h00, 32'h0000_0080);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("bare launch", 32'h0000_00D0, r);
      apb(1'b1, 8'h00, 32'h0000_0030);
      // Enable low longer than a whole erase: the erase must still be running after
      launch(8'h41, 8'hFF);
      en <= 1'b0;
      repeat (2000) @(posedge ref_clk);
      en <= 1'b1;
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("frozen erase", 32'h0000_0080, r);
      wait_done();
      chk("resumed erase", 32'h0000_00C0, r);
      apb(1'b1, 8'h00, 32'h0000_0030);
      launch(8'h41, 8'hFF);
      trig <= 1'b1;
      wait_done();
      trig <= 1'b0;
      chk("stop abort", 32'h0000_00D0, r);
      $display("test errors done");
      apb(1'b0, 8'h1C, 32'h0000_0000);
      chk("unmapped error", 32'h0000_0001, {31'h0, e});
      chk("unmapped data", 32'h0000_0000, r);
      $display("test bus done");
      // Slow divider keeps the first burst running while the second queues
      apb(1'b1, 8'h00, 32'h0000_0030);
      apb(1'b1, 8'h08, 32'h0000_007F);
      launch(8'h25, 8'hF0);
      launch(8'h25, 8'h0F);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("burst queued", 32'h0000_0000, r);
      wait_done();
      chk("burst drained", 32'h0000_00C0, r);
      $display("test burst done");
      print_verdict();
   end
endmodule : flash_command_status_ctrl_tb
`default_nettype wire
